// ===== bus_cond_detect.sv
`include "clk_cfg_defines.svh"
// samples the two-wire lines and reports edges and bus conditions
module bus_cond_detect (
  // clock and reset
  input  wire logic SYS_CLK_I,
  input  wire logic RST_N_I,
  // two-wire lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // events and data line
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o,
  output logic      sda_o
);
  logic scl_q_ff, sda_q_ff;
  logic nxt_scl_q, nxt_sda_q;

  // previous line levels
  always_comb begin
    nxt_scl_q = scl_i;
    nxt_sda_q = sda_i;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
    end
  end

  // edges and conditions
  assign scl_rise_o = scl_i & ~scl_q_ff;
  assign scl_fall_o = ~scl_i & scl_q_ff;
  assign start_o    = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_o     = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign sda_o      = sda_i;
endmodule // bus_cond_detect

// ===== clk_cfg_defines.svh
// Functional notes
// - start, 7-bit address, write bit, ack
// - command code msb one means byte access
// - command low seven bits give register offset
// - byte write: data, update, ack, stop
// - byte read: restart, read address, data, nack
// - reg0 bits 7:5 return latched straps
// - management bit sticky, cleared only by reset
// - power-down with bit0 zero forces full reset
// - reg1 bit6 cpu pll spread type
// - reg1 bit5 panel spread type
// - reg1 bits 3:1 panel spread magnitude
// - reg2 bit7 reference clock enable
// - reg2 bit6 48 MHz output enable
// - reg2 bits 5:0 bus clock enables
// - device write address is D2 hex
// - all-zero command selects block transfer; the code nacks any command with msb zero
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH
`define DEV_ADDR        7'h69
`define OFS_REG0        7'h00
`define OFS_REG1        7'h01
`define OFS_REG2        7'h02
`define RST_REG0        8'h01
`define RST_REG1        8'h85
`define RST_REG2        8'hff
`define REG0_WMASK      8'h0f
`define BIT_MGMT        4
`define BIT_PDCFG       0
`define BIT_CMD_BYTE    7
`define BIT_CNT_LAST    3'h7
`define BIT_CNT_ZERO    3'h0
`endif

// ===== clk_cfg_pkg.sv
package clk_cfg_pkg;
  typedef struct packed {
    logic       cpu_center;
    logic       panel_center;
    logic [2:0] panel_mag;
  } spread_cfg_t;
  typedef struct packed {
    logic       ref_en;
    logic       usb48_en;
    logic [5:0] bus_clk_en;
  } out_en_t;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_ACK   = 7'b000_0100,
    ST_RECV  = 7'b000_1000,
    ST_SEND  = 7'b001_0000,
    ST_MACK  = 7'b010_0000,
    ST_WAIT  = 7'b100_0000
  } ser_state_t;
endpackage

// ===== clk_cfg_regs.sv
`include "clk_cfg_defines.svh"
// two-wire slave with the first three configuration registers
module clk_cfg_regs (
  // clock and power-on reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_N_I,
  // two-wire serial port
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_O,
  // straps and power down
  input  wire logic              FREQ_SELECT_HI_I,
  input  wire logic              FREQ_SELECT_MID_I,
  input  wire logic              FREQ_SELECT_LO_I,
  input  wire logic              POWER_DOWN_N_I,
  // configuration outputs
  output logic                   MGMT_MODE_O,
  output logic                   FULL_RESET_O,
  output clk_cfg_pkg::spread_cfg_t SPREAD_O,
  output clk_cfg_pkg::out_en_t   OUT_EN_O
);
  logic scl_rise, scl_fall, start_c, stop_c, sda_in;

  bus_cond_detect u_det (
    .SYS_CLK_I  (SYS_CLK_I),
    .RST_N_I    (RST_N_I),
    .scl_i      (SCL_I),
    .sda_i      (SDA_I),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_c),
    .stop_o     (stop_c),
    .sda_o      (sda_in)
  );

  clk_cfg_pkg::ser_state_t state_ff, nxt_state;
  logic [7:0] shift_ff, nxt_shift;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [1:0] phase_ff, nxt_phase;   // 0 addr,1 cmd,2 data
  logic       rd_ff, nxt_rd;
  logic       cmd_ok_ff, nxt_cmd_ok;
  logic [6:0] ofs_ff, nxt_ofs;
  logic       drv_ff, nxt_drv;
  logic       out_ff, nxt_out;
  logic [7:0] reg0_ff, nxt_reg0;
  logic [7:0] reg1_ff, nxt_reg1;
  logic [7:0] reg2_ff, nxt_reg2;
  logic       relatch_ff, nxt_relatch;
  logic       full_rst_ff, nxt_full_rst;
  logic       skip_ff, nxt_skip;
  logic [7:0] rd_data;
  logic       wr_stb;

  // read mux by offset
  always_comb begin
    if (ofs_ff == `OFS_REG0) begin
      rd_data = reg0_ff;
    end else if (ofs_ff == `OFS_REG1) begin
      rd_data = reg1_ff;
    end else if (ofs_ff == `OFS_REG2) begin
      rd_data = reg2_ff;
    end else begin
      rd_data = 8'h00;
    end
  end

  // serial protocol state machine
  always_comb begin
    nxt_state   = state_ff;
    nxt_shift   = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_phase   = phase_ff;
    nxt_rd      = rd_ff;
    nxt_cmd_ok  = cmd_ok_ff;
    nxt_ofs     = ofs_ff;
    nxt_drv     = drv_ff;
    nxt_out     = out_ff;
    nxt_skip    = skip_ff;
    wr_stb      = 1'b0;
    if (start_c) begin
      nxt_state   = clk_cfg_pkg::ST_ADDR;
      nxt_bit_cnt = `BIT_CNT_ZERO;
      nxt_phase   = 2'd0;
      nxt_skip    = 1'b1;          // start's own scl fall comes next
      nxt_drv     = 1'b0;
    end else if (stop_c) begin
      nxt_state = clk_cfg_pkg::ST_IDLE;
      nxt_drv   = 1'b0;
    end else begin
      case (state_ff)
        clk_cfg_pkg::ST_IDLE: begin
          nxt_drv = 1'b0;
        end
        clk_cfg_pkg::ST_ADDR, clk_cfg_pkg::ST_RECV: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_in};
          end
          if (scl_fall && skip_ff) begin
            nxt_skip = 1'b0;           // not a data bit, ends the start
          end else if (scl_fall) begin
            if (bit_cnt_ff == `BIT_CNT_LAST) begin
              nxt_bit_cnt = `BIT_CNT_ZERO;
              nxt_state   = clk_cfg_pkg::ST_ACK;
              nxt_drv     = 1'b1;
              if (phase_ff == 2'd0) begin
                if (shift_ff[7:1] == `DEV_ADDR) begin
                  nxt_rd = shift_ff[0];
                  if (shift_ff[0] && !cmd_ok_ff) begin
                    nxt_drv   = 1'b0;
                    nxt_state = clk_cfg_pkg::ST_WAIT;
                  end
                end else begin
                  nxt_drv   = 1'b0;
                  nxt_state = clk_cfg_pkg::ST_WAIT;
                end
              end else if (phase_ff == 2'd1) begin
                nxt_cmd_ok = shift_ff[`BIT_CMD_BYTE];
                nxt_ofs    = shift_ff[6:0];
                if (!shift_ff[`BIT_CMD_BYTE]) begin
                  nxt_drv   = 1'b0;
                  nxt_state = clk_cfg_pkg::ST_WAIT;
                end
              end else begin
                wr_stb = cmd_ok_ff;
              end
            end else begin
              nxt_bit_cnt = bit_cnt_ff + 3'd1;
            end
          end
        end
        clk_cfg_pkg::ST_ACK: begin
          nxt_out = 1'b0;
          if (scl_fall) begin
            if (rd_ff && phase_ff == 2'd0) begin
              nxt_state = clk_cfg_pkg::ST_SEND;
              nxt_drv   = 1'b1;
              nxt_out   = rd_data[7];
              nxt_shift = {rd_data[6:0], 1'b0};
            end else begin
              nxt_drv   = 1'b0;
              nxt_state = (phase_ff == 2'd2) ? clk_cfg_pkg::ST_WAIT
                                             : clk_cfg_pkg::ST_RECV;
              nxt_phase = phase_ff + 2'd1;
            end
          end
        end
        clk_cfg_pkg::ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_ff == `BIT_CNT_LAST) begin
              nxt_bit_cnt = `BIT_CNT_ZERO;
              nxt_drv     = 1'b0;
              nxt_state   = clk_cfg_pkg::ST_MACK;
            end else begin
              nxt_bit_cnt = bit_cnt_ff + 3'd1;
              nxt_out     = shift_ff[7];
              nxt_shift   = {shift_ff[6:0], 1'b0};
            end
          end
        end
        clk_cfg_pkg::ST_MACK: begin
          // master ack or nack ends the read; stop follows
          if (scl_fall) begin
            nxt_state = clk_cfg_pkg::ST_WAIT;
          end
        end
        default: begin
          nxt_drv = 1'b0;
        end
      endcase
    end
  end

  // register updates and power-down reset
  always_comb begin
    nxt_reg0     = reg0_ff;
    nxt_reg1     = reg1_ff;
    nxt_reg2     = reg2_ff;
    nxt_relatch  = 1'b0;
    nxt_full_rst = 1'b0;
    if (!POWER_DOWN_N_I && !reg0_ff[`BIT_PDCFG]) begin
      // emulated cold start, straps caught again
      nxt_reg0     = `RST_REG0;
      nxt_reg1     = `RST_REG1;
      nxt_reg2     = `RST_REG2;
      nxt_relatch  = 1'b1;
      nxt_full_rst = 1'b1;
    end else begin
      if (relatch_ff) begin
        nxt_reg0[7:5] = {FREQ_SELECT_HI_I, FREQ_SELECT_MID_I,
                         FREQ_SELECT_LO_I};
      end
      if (wr_stb) begin
        if (ofs_ff == `OFS_REG0) begin
          nxt_reg0 = (reg0_ff & ~`REG0_WMASK) |
                     (shift_ff & `REG0_WMASK);
          nxt_reg0[`BIT_MGMT] = reg0_ff[`BIT_MGMT] |
                                shift_ff[`BIT_MGMT];
        end else if (ofs_ff == `OFS_REG1) begin
          nxt_reg1 = shift_ff;
        end else if (ofs_ff == `OFS_REG2) begin
          nxt_reg2 = shift_ff;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff    <= clk_cfg_pkg::ST_IDLE;
      shift_ff    <= 8'h00;
      bit_cnt_ff  <= `BIT_CNT_ZERO;
      phase_ff    <= 2'd0;
      rd_ff       <= 1'b0;
      cmd_ok_ff   <= 1'b0;
      ofs_ff      <= 7'h00;
      drv_ff      <= 1'b0;
      out_ff      <= 1'b0;
      reg0_ff     <= `RST_REG0;
      reg1_ff     <= `RST_REG1;
      reg2_ff     <= `RST_REG2;
      relatch_ff  <= 1'b1;
      full_rst_ff <= 1'b0;
      skip_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      shift_ff    <= nxt_shift;
      bit_cnt_ff  <= nxt_bit_cnt;
      phase_ff    <= nxt_phase;
      rd_ff       <= nxt_rd;
      cmd_ok_ff   <= nxt_cmd_ok;
      ofs_ff      <= nxt_ofs;
      drv_ff      <= nxt_drv;
      out_ff      <= nxt_out;
      reg0_ff     <= nxt_reg0;
      reg1_ff     <= nxt_reg1;
      reg2_ff     <= nxt_reg2;
      relatch_ff  <= nxt_relatch;
      full_rst_ff <= nxt_full_rst;
      skip_ff     <= nxt_skip;
    end
  end

  // outputs: sda open drain, low only
  assign SDA_O        = 1'b0;
  assign SDA_OE_O     = drv_ff & ~out_ff;
  assign MGMT_MODE_O  = reg0_ff[`BIT_MGMT];
  assign FULL_RESET_O = full_rst_ff;
  assign SPREAD_O     = '{cpu_center: reg1_ff[6], panel_center: reg1_ff[5],
                          panel_mag: reg1_ff[3:1]};
  assign OUT_EN_O     = '{ref_en: reg2_ff[7], usb48_en: reg2_ff[6],
                          bus_clk_en: reg2_ff[5:0]};
endmodule // clk_cfg_regs

// ===== clk_cfg_regs_chk.sv
module clk_cfg_regs_chk (
  // clock and reset
  input wire logic                     SYS_CLK_I,
  input wire logic                     RST_N_I,
  // serial pins and power down
  input wire logic                     SCL_I,
  input wire logic                     SDA_I,
  input wire logic                     SDA_O,
  input wire logic                     SDA_OE_O,
  input wire logic                     POWER_DOWN_N_I,
  // configuration outputs
  input wire logic                     MGMT_MODE_O,
  input wire logic                     FULL_RESET_O,
  input wire clk_cfg_pkg::spread_cfg_t SPREAD_O,
  input wire clk_cfg_pkg::out_en_t     OUT_EN_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // data line is only ever pulled low, and drive starts and ends only while scl low
  a_od_low: assert property (SDA_OE_O |-> !SDA_O && !SDA_I)
    else $error("sda driven high");
  a_drive_start: assert property ($rose(SDA_OE_O) |-> !SCL_I)
    else $error("drive began with scl high");
  a_drive_end: assert property ($fell(SDA_OE_O) |-> !SCL_I)
    else $error("drive ended with scl high");
  a_hold_high: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
    else $error("sda moved with scl high");
  // spread and output-enable updates land while scl low; management bit stays set
  a_cfg_scl_low: assert property (!FULL_RESET_O && !$past(FULL_RESET_O)
    && (!$stable(OUT_EN_O) || !$stable(SPREAD_O)) |-> !SCL_I)
    else $error("config changed with scl high");
  a_mgmt_sticky: assert property (MGMT_MODE_O && POWER_DOWN_N_I
    && !FULL_RESET_O |=> MGMT_MODE_O)
    else $error("management bit cleared");
  // emulated cold reset
  a_fr_cause: assert property ($rose(FULL_RESET_O) |-> !$past(POWER_DOWN_N_I))
    else $error("full reset without power down");
  a_fr_defaults: assert property ($fell(FULL_RESET_O) |-> SPREAD_O == 5'h02
    && OUT_EN_O == 8'hff && !MGMT_MODE_O)
    else $error("defaults not restored");
  // main scenarios
  c_ack: cover property ($rose(SDA_OE_O));
  c_mgmt: cover property ($rose(MGMT_MODE_O));
  c_fr: cover property ($fell(FULL_RESET_O));
endmodule // clk_cfg_regs_chk
bind clk_cfg_regs clk_cfg_regs_chk u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
  .SDA_I(SDA_I),
  .SDA_OE_O(SDA_OE_O), .POWER_DOWN_N_I(POWER_DOWN_N_I),
  .MGMT_MODE_O(MGMT_MODE_O), .FULL_RESET_O(FULL_RESET_O),
  .SPREAD_O(SPREAD_O), .OUT_EN_O(OUT_EN_O));

// ===== smb_master.sv
// serial bus master, 5-clock phases
module smb_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: both lines released
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic ph;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  // data set mid low phase, msb first
  task automatic sb(input logic b);
    ph;
    pull_o = !b;
    ph;
    scl_o = 1'b1;
    ph;
    scl_o = 1'b0;
  endtask
  task automatic rb(output logic b);
    pull_o = 1'b0;
    ph;
    ph;
    scl_o = 1'b1;
    ph;
    b = sda_i;
    scl_o = 1'b0;
  endtask
  // start or repeated start, then stop
  task automatic st;
    pull_o = 1'b0;
    ph;
    scl_o = 1'b1;
    ph;
    pull_o = 1'b1;
    ph;
    scl_o = 1'b0;
  endtask
  task automatic sp;
    ph;
    pull_o = 1'b1;
    ph;
    scl_o = 1'b1;
    ph;
    pull_o = 1'b0;
    ph;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) sb(d[i]);
    rb(b);
    a = !b;
  endtask
  // byte write and byte read transactions
  task automatic wr(input logic [7:0] a, c, d, output logic [2:0] k);
    st;
    wbyte(a, k[2]);
    wbyte(c, k[1]);
    wbyte(d, k[0]);
    sp;
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d,
                    output logic [2:0] k);
    st;
    wbyte(8'hd2, k[2]);
    wbyte(c, k[1]);
    st;
    wbyte(8'hd3, k[0]);
    for (int i = 7; i >= 0; i--) rb(d[i]);
    sb(1'b1);
    sp;
  endtask
endmodule // smb_master

// ===== tb_clk_cfg_regs.sv
module tb_clk_cfg_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       clk, rst_n, pd_n, scl, pl, oe, mgmt, frst;
  logic [2:0]                 fs;
  logic [7:0]                 c;
  logic [7:0]                 mdl [3];
  clk_cfg_pkg::spread_cfg_t   spr;
  clk_cfg_pkg::out_en_t       oen;
  int                         err_count = 0;
  int                         compares = 0;
  int                         cyc = 0;
  wire                        sda = !(oe | pl);
  clk_cfg_regs dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(), .SDA_OE_O(oe), .FREQ_SELECT_HI_I(fs[2]),
    .FREQ_SELECT_MID_I(fs[1]), .FREQ_SELECT_LO_I(fs[0]),
    .POWER_DOWN_N_I(pd_n), .MGMT_MODE_O(mgmt), .FULL_RESET_O(frst),
    .SPREAD_O(spr), .OUT_EN_O(oen));
  smb_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pl));
  task automatic chk(input string n, input logic [7:0] e, s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // model reset: straps, 0x85, 0xff
  task automatic rmdl;
    mdl[0] = {fs, 5'h01};
    mdl[1] = 8'h85;
    mdl[2] = 8'hff;
  endtask
  task automatic wr(input logic [7:0] a, c, d, input logic [2:0] ea);
    logic [2:0] k;
    m.wr(a, c, d, k);
    chk("wr ack", {5'h00, ea}, {5'h00, k});
    if (ea == 3'h7 && c[6:0] == 7'h00)
      mdl[0] = {mdl[0][7:5], mdl[0][4] | d[4], d[3:0]};
    else if (ea == 3'h7 && c[6:0] < 7'h03) mdl[c[1:0]] = d;
  endtask
  task automatic rd(input logic [7:0] c);
    logic [7:0] d;
    logic [2:0] k;
    m.rd(c, d, k);
    chk("rd ack", 8'h07, {5'h00, k});
    chk("rd data", c[6:0] < 7'h03 ? mdl[c[1:0]] : 8'h00, d);
    chk("spread", {3'h0, mdl[1][6:5], mdl[1][3:1]}, {3'h0, spr});
    chk("out en", mdl[2], oen);
    chk("mgmt", {7'h00, mdl[0][4]}, {7'h00, mgmt});
  endtask
  task automatic pdn(input logic e);
    @(posedge clk);
    #1 pd_n = 1'b0;
    fs = ~fs;
    @(posedge clk);
    #1 chk("full reset", {7'h00, e}, {7'h00, frst});
    repeat (9) @(posedge clk);
    #1 pd_n = 1'b1;
    repeat (5) @(posedge clk);
    if (e) rmdl;
    for (int i = 0; i < 3; i++) rd(8'h80 + 8'(i));
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      results;
    end
  end
  initial begin
    rst_n = 1'b0;
    pd_n = 1'b1;
    void'($urandom(32'hb3eb));
    fs = 3'($urandom);
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rmdl;
    for (int i = 0; i < 3; i++) rd(8'h80 + 8'(i));
    for (int i = 0; i < 12; i++) begin
      c = 8'h81 + 8'(i % 2);
      wr(8'hd2, c, 8'($urandom), 3'h7);
      rd(c);
    end
    wr(8'hd2, 8'h80, 8'hff, 3'h7);
    rd(8'h80);
    pdn(1'b0);
    wr(8'hd2, 8'h80, 8'h00, 3'h7);
    rd(8'h80);
    wr(8'hd2, 8'hfe, 8'h5a, 3'h7);
    rd(8'hfe);
    wr(8'hd4, 8'h81, 8'h00, 3'h0);
    wr(8'hd2, 8'h00, 8'h00, 3'h4);
    rd(8'h81);
    pdn(1'b1);
    results;
  end
endmodule // tb_clk_cfg_regs
